/* File: logic/uart_line_pkg.sv */
package uart_line_pkg;

    // Baud sampling rate: sample ticks in one bit cell.
    localparam int SAMPLES_PER_BIT = 16;

    // Infrared pulse widths in sample ticks (3/16 and 1/4 of a bit).
    localparam logic [4:0] IR10_PULSE_TICKS = 5'h03;
    localparam logic [4:0] IR11_PULSE_TICKS = 5'h04;
    localparam logic [4:0] IR_STRETCH_TICKS = 5'h10;

    // Values after reset, the asserted direction level and the strap capture age.
    localparam logic       RX_AUTO_EN_RESET = 1'b0;
    localparam logic       PIN_MARK         = 1'b1;
    localparam logic       DIR_ASSERTED     = 1'b0;
    localparam logic [1:0] STRAP_READY_AGE  = 2'h2;

    // Word length codes of the line control field.
    localparam logic [1:0] WLEN_5 = 2'h0;
    localparam logic [1:0] WLEN_6 = 2'h1;
    localparam logic [1:0] WLEN_7 = 2'h2;

    // Control bits gathered from the host-side registers.
    typedef struct packed {
        logic       special_detect;  // enhanced_feature_reg bit 5
        logic       multidrop;       // extra_feature_ctrl_reg bit 0
        logic       auto_dir;        // extra_feature_ctrl_reg bit 4
        logic       dir_invert;      // extra_feature_ctrl_reg bit 5
        logic       ir_v11;          // extra_feature_ctrl_reg bit 7
        logic       mcr_ir;          // modem_control_reg bit 6
        logic       loopback;        // modem_control_reg bit 4
        logic       sleep_en;        // interrupt_enable_reg bit 4
        logic [1:0] wlen;            // line_control_reg bits 1:0
        logic [7:0] match_char;      // special_match_char
    } line_cfg_type;

    // Character from the receive shift register.
    typedef struct packed {
        logic [7:0] data;
        logic       parity;
        logic       parity_err;
    } rx_char_type;

    // Entry written into the receive FIFO.
    typedef struct packed {
        logic [7:0] data;
        logic       parity_err;
    } rx_push_type;

    typedef enum logic [2:0] {
        DIR_IDLE = 3'b001,
        DIR_LEAD = 3'b010,
        DIR_SEND = 3'b100
    } dir_state_type;

    typedef enum logic [1:0] {
        PWR_AWAKE = 2'b01,
        PWR_SLEEP = 2'b10
    } pwr_state_type;

endpackage : uart_line_pkg

/* File: logic/ir_encoder.sv */
`timescale 1ns/1ps
module ir_encoder
    import uart_line_pkg::*;
#(
    parameter int CNT_W = 5
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_sample_en,
    input  wire logic i_bit_start,
    input  wire logic i_bit,
    input  wire logic i_wide,
    output logic      o_pulse
);

    if (CNT_W < 5) begin : g_chk
        $error("ir_encoder: CNT_W too small for pulse width");
    end

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             pulse;
    } enc_state_type;

    enc_state_type st_q;
    enc_state_type st_d;

    // The pulse starts with the zero bit cell and counts sample ticks.
    always_comb begin
        st_d = st_q;
        if (i_bit_start && !i_bit) begin
            st_d.cnt = CNT_W'(i_wide ? IR11_PULSE_TICKS : IR10_PULSE_TICKS);
        end else if (i_sample_en && st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
        st_d.pulse = st_d.cnt != '0;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_pulse = st_q.pulse;

endmodule : ir_encoder

/* File: logic/ir_decoder.sv */
`timescale 1ns/1ps
module ir_decoder
    import uart_line_pkg::*;
#(
    parameter int CNT_W = 5
) (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_sample_en,
    input  wire logic i_level,
    output logic      o_data
);

    if (CNT_W < 5) begin : g_chk
        $error("ir_decoder: CNT_W too small for one bit cell");
    end

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             prev;
        logic             data;
    } dec_state_type;

    dec_state_type st_q;
    dec_state_type st_d;

    // A sensed pulse is stretched to one bit cell of logic 1.
    always_comb begin
        st_d = st_q;
        st_d.prev = i_level;
        if (i_level && !st_q.prev) begin
            st_d.cnt = CNT_W'(IR_STRETCH_TICKS);
        end else if (i_sample_en && st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
        st_d.data = st_d.cnt != '0;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_q      <= '0;
            st_q.prev <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_data = st_q.data;

endmodule : ir_decoder

/* File: logic/uart_line_ext.sv */
`timescale 1ns/1ps
//
// Contract
// - special detect: match char stored, flag set
// - compare only the configured word length bits
// - auto direction idles receive, asserts before sending
// - release direction after final stop bit
// - invert bit flips direction output polarity
// - normal multidrop needs multidrop set, special clear
// - receiver off: drop data, tag addresses
// - receiver on: accept data, interrupt addresses
// - auto address: discard everything until match
// - matching address enables receiver, stored tagged
// - other address disables receiver, dropped
// - infrared mode: 3/16 bit pulse per zero
// - version 1.1 coding: quarter bit pulse
// - infrared transmit and receive idle low
// - each sensed light pulse gives logic 1
// - strap low starts infrared, then control bit
// - sleep only when all four conditions hold
// - wake on start edge, load, modem change
// - re-sleep when interrupts clear, until disabled
// - loopback feeds transmit into receive
// - loopback holds pins, ignores modem inputs
module uart_line_ext
    import uart_line_pkg::*;
(
    input  wire logic         i_clk,
    input  wire logic         i_reset,
    input  wire logic         i_sample_en,
    input  wire line_cfg_type i_cfg,
    input  wire logic         i_rx_enable_sw,
    input  wire logic         i_no_int_pending,
    input  wire logic [3:0]   i_msr_delta,
    input  wire logic         i_rts_n,
    input  wire logic         i_dtr_n,
    input  wire logic         i_tx_load,
    input  wire logic         i_tx_fifo_empty,
    input  wire logic         i_tx_busy,
    input  wire logic         i_tx_serial,
    input  wire logic         i_tx_bit_start,
    input  wire logic         i_rx_valid,
    input  wire rx_char_type  i_rx_char,
    input  wire logic         i_rx_pin,
    input  wire logic [3:0]   i_modem_pin_n,
    input  wire logic         i_infrared_strap_n,
    output logic              o_rx_push,
    output rx_push_type       o_rx_push_data,
    output logic              o_lsr_event,
    output logic              o_special_event,
    output logic              o_rx_auto_enabled,
    output logic              o_rx_serial,
    output logic              o_tx_pin,
    output logic              o_rts_n_pin,
    output logic              o_dtr_n_pin,
    output logic [3:0]        o_modem_n,
    output logic              o_tx_allow,
    output logic              o_autoflow_en,
    output logic              o_ir_active,
    output logic              o_osc_stop
);

    typedef struct packed {
        logic          rx_meta;
        logic          rx_sync;
        logic          rx_prev;
        logic [3:0]    modem_meta;
        logic [3:0]    modem_sync;
        logic [3:0]    modem_prev;
        logic          strap_meta;
        logic          strap_sync;
        logic [1:0]    strap_age;
        logic          ir_strap;
        logic          ir_from_mcr;
        logic          mcr_ir_prev;
        logic          auto_en;
        dir_state_type dir;
        pwr_state_type pwr;
        logic          push;
        rx_push_type   push_data;
        logic          lsr_evt;
        logic          special_evt;
        logic          rx_serial;
        logic          tx_pin;
        logic          rts_pin;
        logic          dtr_pin;
        logic [3:0]    modem_out;
        logic          tx_allow;
        logic          autoflow_en;
        logic          ir_active;
        logic          osc_stop;
    } state_type;

    state_type st_q;
    state_type st_d;
    logic      ir_enc;
    logic      ir_dec;

    // Keeps only the bits that the configured word length carries.
    function automatic logic [7:0] char_mask(input logic [1:0] wlen);
        case (wlen)
            WLEN_5:  char_mask = 8'h1f;
            WLEN_6:  char_mask = 8'h3f;
            WLEN_7:  char_mask = 8'h7f;
            default: char_mask = 8'hff;
        endcase
    endfunction : char_mask

    function automatic logic char_hit(input logic [7:0] a, input logic [7:0] b, input logic [1:0] wlen);
        char_hit = (a & char_mask(wlen)) == (b & char_mask(wlen));
    endfunction : char_hit

    ir_encoder #(
        .CNT_W (5)
    ) u_enc (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_sample_en (i_sample_en),
        .i_bit_start (i_tx_bit_start),
        .i_bit       (i_tx_serial),
        .i_wide      (i_cfg.ir_v11),
        .o_pulse     (ir_enc)
    );

    ir_decoder #(
        .CNT_W (5)
    ) u_dec (
        .i_clk       (i_clk),
        .i_reset     (i_reset),
        .i_sample_en (i_sample_en),
        .i_level     (st_q.rx_sync),
        .o_data      (ir_dec)
    );

    always_comb begin
        logic ir_on;
        logic lb;
        logic hit;
        logic wake;
        logic can_sleep;
        ir_on     = 1'b0;
        lb        = i_cfg.loopback;
        hit       = char_hit(i_rx_char.data, i_cfg.match_char, i_cfg.wlen);
        wake      = 1'b0;
        can_sleep = 1'b0;
        st_d      = st_q;

        st_d.rx_meta    = i_rx_pin;
        st_d.rx_sync    = st_q.rx_meta;
        st_d.rx_prev    = st_q.rx_sync;
        st_d.modem_meta = i_modem_pin_n;
        st_d.modem_sync = st_q.modem_meta;
        st_d.modem_prev = st_q.modem_sync;
        st_d.strap_meta = i_infrared_strap_n;
        st_d.strap_sync = st_q.strap_meta;

        // The strap is caught once the synchroniser has filled after reset.
        if (st_q.strap_age != 2'h3) begin
            st_d.strap_age = st_q.strap_age + 2'h1;
        end
        if (st_q.strap_age == STRAP_READY_AGE) begin
            st_d.ir_strap = ~st_q.strap_sync;
        end
        if (i_cfg.mcr_ir != st_q.mcr_ir_prev) begin
            st_d.ir_from_mcr = 1'b1;
        end
        st_d.mcr_ir_prev = i_cfg.mcr_ir;
        ir_on = st_q.ir_from_mcr ? i_cfg.mcr_ir : st_q.ir_strap;
        st_d.ir_active = ir_on;

        // Receive character handling by mode.
        st_d.push        = 1'b0;
        st_d.lsr_evt     = 1'b0;
        st_d.special_evt = 1'b0;
        if (!(i_cfg.multidrop && i_cfg.special_detect)) begin
            st_d.auto_en = RX_AUTO_EN_RESET;
        end
        if (i_rx_valid) begin
            st_d.push_data.data       = i_rx_char.data;
            st_d.push_data.parity_err = i_rx_char.parity_err;
            if (i_cfg.multidrop && i_cfg.special_detect) begin
                if (i_rx_char.parity) begin
                    if (hit) begin
                        st_d.auto_en              = 1'b1;
                        st_d.push                 = 1'b1;
                        st_d.push_data.parity_err = i_rx_char.parity;
                        st_d.lsr_evt              = 1'b1;
                    end else begin
                        st_d.auto_en = 1'b0;
                    end
                end else begin
                    st_d.push = st_q.auto_en;
                end
            end else if (i_cfg.multidrop) begin
                if (i_rx_char.parity) begin
                    st_d.push                 = 1'b1;
                    st_d.push_data.parity_err = 1'b1;
                    st_d.lsr_evt              = 1'b1;
                end else begin
                    st_d.push = i_rx_enable_sw;
                end
            end else begin
                st_d.push        = 1'b1;
                st_d.special_evt = i_cfg.special_detect && hit;
            end
        end

        // Line routing; loopback holds the outgoing pins where they stand.
        if (lb) begin
            st_d.rx_serial = i_tx_serial;
            st_d.modem_out = {PIN_MARK, PIN_MARK, i_dtr_n, i_rts_n};
        end else begin
            st_d.rx_serial = ir_on ? ir_dec : st_q.rx_sync;
            st_d.tx_pin    = ir_on ? ir_enc : i_tx_serial;
            st_d.dtr_pin   = i_dtr_n;
            st_d.modem_out = st_q.modem_sync;
        end
        st_d.autoflow_en = ~lb;

        // Direction control: one cycle of lead before the transmitter may go.
        case (st_q.dir)
            DIR_IDLE: begin
                if (i_tx_load || !i_tx_fifo_empty || i_tx_busy) begin
                    st_d.dir = DIR_LEAD;
                end
            end
            DIR_LEAD: begin
                st_d.dir = DIR_SEND;
            end
            DIR_SEND: begin
                if (!i_tx_busy && i_tx_fifo_empty && !i_tx_load) begin
                    st_d.dir = DIR_IDLE;
                end
            end
            default: begin
                st_d.dir = DIR_IDLE;
            end
        endcase
        if (!i_cfg.auto_dir) begin
            st_d.dir = DIR_IDLE;
        end
        st_d.tx_allow = !i_cfg.auto_dir || st_d.dir == DIR_SEND;
        if (!lb) begin
            if (i_cfg.auto_dir) begin
                st_d.rts_pin = ((st_d.dir == DIR_IDLE) ? ~DIR_ASSERTED : DIR_ASSERTED) ^ i_cfg.dir_invert;
            end else begin
                st_d.rts_pin = i_rts_n;
            end
        end

        // Sleep: the clock outside is gated from o_osc_stop.
        wake = (!lb && st_q.rx_prev && !st_q.rx_sync)
            || i_tx_load
            || (!lb && st_q.modem_sync != st_q.modem_prev);
        can_sleep = i_no_int_pending && i_cfg.sleep_en && i_msr_delta == 4'h0
            && st_q.rx_sync && !wake && i_tx_fifo_empty && !i_tx_busy;
        case (st_q.pwr)
            PWR_AWAKE: begin
                if (can_sleep) begin
                    st_d.pwr = PWR_SLEEP;
                end
            end
            PWR_SLEEP: begin
                if (wake || !i_cfg.sleep_en || !i_no_int_pending) begin
                    st_d.pwr = PWR_AWAKE;
                end
            end
            default: begin
                st_d.pwr = PWR_AWAKE;
            end
        endcase
        st_d.osc_stop = st_d.pwr == PWR_SLEEP;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_q             <= '0;
            st_q.rx_meta     <= PIN_MARK;
            st_q.rx_sync     <= PIN_MARK;
            st_q.rx_prev     <= PIN_MARK;
            st_q.modem_meta  <= 4'hf;
            st_q.modem_sync  <= 4'hf;
            st_q.modem_prev  <= 4'hf;
            st_q.strap_meta  <= PIN_MARK;
            st_q.strap_sync  <= PIN_MARK;
            st_q.dir         <= DIR_IDLE;
            st_q.pwr         <= PWR_AWAKE;
            st_q.rx_serial   <= PIN_MARK;
            st_q.tx_pin      <= PIN_MARK;
            st_q.rts_pin     <= PIN_MARK;
            st_q.dtr_pin     <= PIN_MARK;
            st_q.modem_out   <= 4'hf;
            st_q.tx_allow    <= 1'b1;
            st_q.autoflow_en <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rx_push         = st_q.push;
    assign o_rx_push_data    = st_q.push_data;
    assign o_lsr_event       = st_q.lsr_evt;
    assign o_special_event   = st_q.special_evt;
    assign o_rx_auto_enabled = st_q.auto_en;
    assign o_rx_serial       = st_q.rx_serial;
    assign o_tx_pin          = st_q.tx_pin;
    assign o_rts_n_pin       = st_q.rts_pin;
    assign o_dtr_n_pin       = st_q.dtr_pin;
    assign o_modem_n         = st_q.modem_out;
    assign o_tx_allow        = st_q.tx_allow;
    assign o_autoflow_en     = st_q.autoflow_en;
    assign o_ir_active       = st_q.ir_active;
    assign o_osc_stop        = st_q.osc_stop;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    logic mode_auto;
    logic mode_norm;
    logic mode_spec;
    assign mode_auto = i_cfg.multidrop && i_cfg.special_detect;
    assign mode_norm = i_cfg.multidrop && !i_cfg.special_detect;
    assign mode_spec = !i_cfg.multidrop && i_cfg.special_detect;

    chk_special_flag_set: assert property (
        i_rx_valid && mode_spec && char_hit(i_rx_char.data, i_cfg.match_char, i_cfg.wlen)
        |=> o_special_event && o_rx_push && o_rx_push_data.data == $past(i_rx_char.data))
        else $error("special character not flagged and stored");
    chk_wlen_mask_short: assert property (
        i_rx_valid && mode_spec && i_cfg.wlen == WLEN_5 && i_rx_char.data[4:0] == i_cfg.match_char[4:0]
        |=> o_special_event)
        else $error("upper bits wrongly used in short word compare");
    chk_dir_before_send: assert property (
        !$past(i_reset) && $past(i_cfg.auto_dir && !i_cfg.loopback) && $stable(i_cfg.dir_invert) && o_tx_allow
        |-> o_rts_n_pin == (DIR_ASSERTED ^ i_cfg.dir_invert))
        else $error("transmitter allowed without direction asserted");
    chk_dir_lead_cycle: assert property (
        $rose(st_q.dir == DIR_LEAD) |-> !o_tx_allow ##1 o_tx_allow)
        else $error("direction lead cycle missing");
    chk_dir_hold_busy: assert property (
        i_cfg.auto_dir && st_q.dir == DIR_SEND && i_tx_busy |=> st_q.dir == DIR_SEND)
        else $error("direction released while a character is still shifting");
    chk_md_discard_data: assert property (
        i_rx_valid && mode_norm && !i_rx_enable_sw && !i_rx_char.parity |=> !o_rx_push)
        else $error("data byte stored while receiver disabled");
    chk_md_address_tag: assert property (
        i_rx_valid && mode_norm && i_rx_char.parity
        |=> o_rx_push && o_rx_push_data.parity_err && o_lsr_event)
        else $error("address byte not tagged in multidrop");
    chk_auto_wait_drop: assert property (
        i_rx_valid && mode_auto && !st_q.auto_en && !i_rx_char.parity |=> !o_rx_push)
        else $error("data stored before address match");
    chk_auto_match_take: assert property (
        i_rx_valid && mode_auto && i_rx_char.parity && char_hit(i_rx_char.data, i_cfg.match_char, i_cfg.wlen)
        |=> st_q.auto_en && o_rx_push && o_rx_push_data.parity_err && o_lsr_event)
        else $error("matching address not taken");
    chk_auto_miss_drop: assert property (
        i_rx_valid && mode_auto && i_rx_char.parity && !char_hit(i_rx_char.data, i_cfg.match_char, i_cfg.wlen)
        |=> !st_q.auto_en && !o_rx_push)
        else $error("other address not dropped");
    chk_sleep_entry_gate: assert property (
        $rose(o_osc_stop) |-> $past(i_no_int_pending && i_cfg.sleep_en && i_msr_delta == 4'h0 && st_q.rx_sync))
        else $error("sleep entered with a condition unmet");
    chk_wake_on_load: assert property (
        o_osc_stop && i_tx_load |=> !o_osc_stop)
        else $error("transmit load did not wake");
    chk_no_sleep_pending: assert property (
        !i_no_int_pending ##1 !i_no_int_pending |-> !o_osc_stop)
        else $error("asleep while an interrupt is pending");
    chk_loop_pins_held: assert property (
        i_cfg.loopback [*3] |-> $stable(o_tx_pin) && $stable(o_rts_n_pin) && $stable(o_dtr_n_pin))
        else $error("pins moved during loopback");
    chk_loop_route: assert property (
        i_cfg.loopback |=> o_rx_serial == $past(i_tx_serial))
        else $error("loopback did not feed the receiver");

    cov_auto_match: cover property (i_rx_valid && mode_auto && i_rx_char.parity ##1 o_rx_push);
    cov_sleep_wake: cover property ($rose(o_osc_stop) ##[1:50] $fell(o_osc_stop));
    cov_dir_cycle: cover property ($fell(o_rts_n_pin) ##[1:200] $rose(o_rts_n_pin));
    cov_special: cover property (o_special_event);

endmodule : uart_line_ext

/* File: tb/uart_line_partner.sv */
`timescale 1ns/1ps
// Line side: marks high normally, idles low in infrared mode, and sends a
// three-cycle start edge or light pulse on request.
module uart_line_partner (
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_ir,
    input  wire logic i_flash,
    output logic      o_rx_pin
);
    logic [1:0] cnt_q;
    always_ff @(posedge i_clk) begin
        if (i_reset) cnt_q <= 2'h0;
        else if (i_flash) cnt_q <= 2'h3;
        else if (cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
    end
    assign o_rx_pin = ~(i_ir ^ (cnt_q != 2'h0));
endmodule : uart_line_partner

/* File: tb/uart_line_ext_tb_top.sv */
`timescale 1ns/1ps
module uart_line_ext_tb_top;
    import uart_line_pkg::*;
    logic clk = 0, rst = 1, rx_en = 0, nopend = 1, load = 0, busy = 0, txs = 1, bstart = 0, vld = 0, flash = 0;
    logic rts = 1, dtr = 1, strap = 1, push, line_status_reg, spec, auto_en, rxs, txp, rtsp, dtrp, allow, afl, irp, stop, rxpin;
    logic [3:0] delta = 4'h0, modem = 4'hf, mod_o;
    logic [7:0] d, m;
    line_cfg_type cfg = '0;
    rx_char_type ch = '0;
    rx_push_type pd;
    logic [10:0] q[$];
    int failures = 0, tests_run = 0, n;
    always #2 clk = ~clk;
    uart_line_ext dut_u (.i_clk(clk), .i_reset(rst), .i_sample_en(1'b1), .i_cfg(cfg), .i_rx_enable_sw(rx_en),
        .i_no_int_pending(nopend), .i_msr_delta(delta), .i_rts_n(rts), .i_dtr_n(dtr), .i_tx_load(load),
        .i_tx_fifo_empty(1'b1), .i_tx_busy(busy), .i_tx_serial(txs), .i_tx_bit_start(bstart),
        .i_rx_valid(vld), .i_rx_char(ch), .i_rx_pin(rxpin), .i_modem_pin_n(modem),
        .i_infrared_strap_n(strap), .o_rx_push(push), .o_rx_push_data(pd), .o_lsr_event(line_status_reg),
        .o_special_event(spec), .o_rx_auto_enabled(auto_en), .o_rx_serial(rxs), .o_tx_pin(txp),
        .o_rts_n_pin(rtsp), .o_dtr_n_pin(dtrp), .o_modem_n(mod_o), .o_tx_allow(allow),
        .o_autoflow_en(afl), .o_ir_active(irp), .o_osc_stop(stop));
    uart_line_partner line_u (.i_clk(clk), .i_reset(rst), .i_ir(cfg.mcr_ir), .i_flash(flash), .o_rx_pin(rxpin));
    task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done;
        if (failures == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc
    // The expected entry is noted as the character is offered: {push, tag, line event, special}.
    task automatic rx(input logic [7:0] dv, input logic p, input logic pe, input logic [3:0] e);
        @(negedge clk);
        ch = '{dv, p, pe};
        vld = 1;
        if (e[3]) q.push_back({dv, e[2:0]});
        @(negedge clk);
        vld = 0;
    endtask : rx
    always @(posedge clk) begin
        if (push === 1'b1) chk({pd, line_status_reg, spec}, q.size() ? q.pop_front() : 11'h7ff);
        else if (!rst && (line_status_reg !== 1'b0 || spec !== 1'b0)) chk({line_status_reg, spec}, 0);
    end
    initial begin
        n = $urandom(52460);
        cyc(20);
        rst = 0;
        cyc(6);
        cfg.special_detect = 1;
        cfg.match_char = 8'h35;
        for (int w = 0; w < 4; w++) begin
            cfg.wlen = w[1:0];
            m = 8'hff >> (3 - w);
            rx(8'h35 | ~m, 0, 0, 4'b1001);
            d = $urandom;
            d[0] = ~cfg.match_char[0];
            rx(d, 0, 0, 4'b1000);
        end
        cfg.special_detect = 0;
        cfg.multidrop = 1;
        for (int e = 0; e < 2; e++) begin
            rx_en = e[0];
            rx($urandom, 0, 0, {rx_en, 3'b000});
            rx(8'h42, 1, 0, 4'b1110);
        end
        cfg.special_detect = 1;
        cfg.match_char = 8'h5a;
        rx_en = 0;
        rx($urandom, 0, 0, 4'b0000);
        rx(8'h5b, 1, 0, 4'b0000);
        rx(8'h5a, 1, 0, 4'b1110);
        chk(auto_en, 1);
        rx(8'h77, 0, 0, 4'b1000);
        rx(8'h11, 1, 0, 4'b0000);
        chk(auto_en, 0);
        rx(8'h77, 0, 0, 4'b0000);
        cfg.multidrop = 0;
        cfg.special_detect = 0;
        cfg.auto_dir = 1;
        for (int v = 0; v < 2; v++) begin
            cfg.dir_invert = v[0];
            cyc(3);
            chk(rtsp, !cfg.dir_invert);
            load = 1;
            busy = 1;
            @(negedge clk) load = 0;
            chk({rtsp, allow}, {cfg.dir_invert, 1'b0});
            cyc(2);
            chk({rtsp, allow}, {cfg.dir_invert, 1'b1});
            cyc(20);
            chk(rtsp, cfg.dir_invert);
            busy = 0;
            cyc(3);
            chk({rtsp, allow}, {!cfg.dir_invert, 1'b0});
        end
        cfg.auto_dir = 0;
        cfg.dir_invert = 0;
        cfg.mcr_ir = 1;
        cyc(4);
        chk({txp, irp, allow}, 3'b011);
        for (int v = 0; v < 2; v++) begin
            cfg.ir_v11 = v[0];
            txs = 0;
            bstart = 1;
            @(negedge clk) bstart = 0;
            n = 0;
            repeat (20) begin
                @(negedge clk);
                if (txp === 1'b1) n++;
            end
            chk(n[10:0], v ? 11'h004 : 11'h003);
        end
        txs = 1;
        flash = 1;
        @(negedge clk) flash = 0;
        n = 0;
        repeat (30) begin
            @(negedge clk);
            if (rxs === 1'b1) n++;
        end
        chk(n[10:0], 16);
        cfg.mcr_ir = 0;
        cfg.ir_v11 = 0;
        cyc(20);
        cfg.loopback = 1;
        rts = 0;
        repeat (8) begin
            txs = $urandom;
            modem = $urandom;
            dtr = $urandom;
            @(negedge clk);
            chk({rxs, txp, rtsp, dtrp, afl, mod_o}, {txs, 3'b111, 1'b0, 2'b11, dtr, rts});
        end
        cfg.loopback = 0;
        rts = 1;
        txs = 1;
        dtr = 1;
        modem = 4'hf;
        cyc(5);
        chk({dtrp, afl}, 2'b11);
        cfg.sleep_en = 1;
        nopend = 0;
        cyc(8);
        chk(stop, 0);
        nopend = 1;
        delta = 4'h1;
        cyc(8);
        chk(stop, 0);
        delta = 4'h0;
        cyc(8);
        chk(stop, 1);
        for (int k = 0; k < 3; k++) begin
            if (k == 0) load = 1;
            else if (k == 1) flash = 1;
            else modem = 4'he;
            n = 0;
            @(negedge clk);
            load = 0;
            flash = 0;
            repeat (8) begin
                if (stop === 1'b0) n++;
                @(negedge clk);
            end
            chk(n != 0, 1);
            cyc(8);
            chk(stop, 1);
        end
        cfg.sleep_en = 0;
        cyc(4);
        chk(stop, 0);
        strap = 0;
        rst = 1;
        cyc(3);
        rst = 0;
        cyc(6);
        chk({irp, txp}, 2'b10);
        cfg.mcr_ir = 1;
        cyc(3);
        cfg.mcr_ir = 0;
        cyc(4);
        chk(irp, 0);
        chk(q.size(), 0);
        test_done;
    end
    initial begin
        #200000;
        failures++;
        test_done;
    end
endmodule : uart_line_ext_tb_top
